/* File: core/tap_pkg.sv */
// test access port controller: shared states, codes, field positions and pin bundle
// assumes one system clock samples the test pins; no software registers exist

package tap_pkg;

  // ------------------------------------------------------------
  // controller states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET      = 4'h0,
    ST_IDLE       = 4'h1,
    ST_SEL_DR     = 4'h2,
    ST_CAPTURE_DR = 4'h3,
    ST_SHIFT_DR   = 4'h4,
    ST_EXIT1_DR   = 4'h5,
    ST_PAUSE_DR   = 4'h6,
    ST_EXIT2_DR   = 4'h7,
    ST_UPDATE_DR  = 4'h8,
    ST_SEL_IR     = 4'h9,
    ST_CAPTURE_IR = 4'ha,
    ST_SHIFT_IR   = 4'hb,
    ST_EXIT1_IR   = 4'hc,
    ST_PAUSE_IR   = 4'hd,
    ST_EXIT2_IR   = 4'he,
    ST_UPDATE_IR  = 4'hf
  } tap_state_t;

  // ------------------------------------------------------------
  // instruction register
  // ------------------------------------------------------------
  localparam int         IR_W       = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  // instruction codes are arbitrary
  localparam logic [3:0] IR_IDCODE  = 4'h1;
  localparam logic [3:0] IR_DATA    = 4'h2;
  localparam logic [3:0] IR_STATUS  = 4'h3;
  localparam logic [3:0] IR_BYPASS  = 4'hf;
  localparam logic [3:0] IR_RESET   = IR_IDCODE;

  // ------------------------------------------------------------
  // data registers
  // ------------------------------------------------------------
  localparam int          DR_W        = 32;
  localparam int          ST_PEND_BIT = 0;
  localparam int          ST_OVF_BIT  = 1;
  localparam int          ST_FULL_BIT = 2;
  localparam int          FIFO_DEPTH  = 32;
  localparam int          SYNC_STAGES = 2;
  // identity value is arbitrary
  localparam logic [31:0] ID_VALUE    = 32'h0000_0001;

  // ------------------------------------------------------------
  // pin bundle from the far controller
  // ------------------------------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_t;

endpackage

/* File: core/pin_sync.sv */
// two-stage synchroniser for a bundle of asynchronous inputs
// assumes each bit is an independent level; only stage two is read outside

`timescale 1ns/1ps

module pin_sync
  import tap_pkg::*;
#(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // bundle
  input  wire logic [W-1:0] d_in,
  output      logic [W-1:0] q_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] hold_r;

  initial begin
    if (W < 1) $error("pin_sync: width must be at least one");
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      hold_r <= '0;
    end else begin
      meta_r <= d_in;
      hold_r <= meta_r;
    end
  end

  assign q_out = hold_r;

endmodule // pin_sync

/* File: core/word_fifo.sv */
// synchronous fifo with registered read data, valid/ready on both sides
// assumes a single clock; out_data only changes when a word is taken or loaded

`timescale 1ns/1ps

module word_fifo
  import tap_pkg::*;
#(
  parameter int W     = 32,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // filling side
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic          out_valid_r;
  logic [W-1:0]  out_data_r;

  initial begin
    if (W < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("word_fifo: width >= 1 and power-of-two depth >= 2 required");
  end

  wire push     = in_valid && in_ready;
  wire out_free = !out_valid_r || out_ready;
  wire pop      = out_free && (count_r != '0);

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = out_valid_r;
  assign out_data  = out_data_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // read data always leave through a register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end else if (out_free) begin
      out_valid_r <= pop;
      if (pop) out_data_r <= mem_r[rd_ptr_r];
    end
  end

endmodule // word_fifo

/* File: core/tap_ctrl.sv */
// test access port controller: sixteen-state machine, instruction and data paths
// assumes tck/tms/tdi are asynchronous pins sampled by clk, far more slowly toggling
// than clk (at least four clk periods per tck level); tdo drive is split into level and enable
//
// Operation
// - controller is a finite state machine of exactly sixteen states
// - each rising test clock edge advances state, chosen by sampled mode-select
// - after power-on reset the machine starts in Test-Logic-Reset
// - every shift register moves least significant bit first, in and out
// - from Run-Test/Idle, mode-select 1,1,0,0 reaches Shift-IR
// - instruction register is four bits, loaded serially from data input in Shift-IR
// - while instruction shifts in, captured pattern 0x01 shifts out
// - active instruction selects the data register between data input and output
// - from either shift state, mode-select 1,1,0 returns to idle via update
// - shifted instruction reaches the parallel output only in Update-IR
// - Exit-IR, Pause-IR and Exit2-IR do no register action
// - from idle, mode-select 1,0,0 reaches Shift-DR, shifting selected register
// - Capture-DR loads parallel inputs; Shift-DR then shifts them out
// - latched parallel data output changes only in Update-DR
// - Exit-DR, Pause-DR and Exit2-DR do no register action
// - mode-select high for five test clocks always reaches Test-Logic-Reset
// - data output is undriven except from a falling test clock edge in a shift state until the next falling edge
// - no dedicated test-reset input; reset by power-on or mode-select only

`timescale 1ns/1ps

module tap_ctrl
  import tap_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int DEPTH  = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // test pins
  input  wire tap_pins_t         pins_in,
  output      logic              tdo_out,
  output      logic              tdo_oe,
  // parallel capture source
  input  wire logic [DATA_W-1:0] cap_data,
  // received words
  output      logic              word_valid,
  input  wire logic              word_ready,
  output      logic [DATA_W-1:0] word_data,
  // controller view
  output      tap_state_t        tap_state,
  output      logic [IR_W-1:0]   active_ir,
  output      logic              logic_reset
);

  initial begin
    if (DATA_W < 1 || DATA_W > DR_W) $error("tap_ctrl: DATA_W must lie in 1..32");
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("tap_ctrl: DEPTH must be a power of two of at least 2");
  end

  // ------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------
  tap_pins_t pins_s;
  logic      tck_q_r;

  pin_sync #(
    .W ($bits(tap_pins_t))
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d_in    (pins_in),
    .q_out   (pins_s)
  );

  // starts low like the idle test clock, so reset brings no false edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tck_q_r <= 1'b0;
    end else begin
      tck_q_r <= pins_s.tck;
    end
  end

  // edges seen on the synchronised copy; tms/tdi were sampled in the same cycle
  wire tck_rise = pins_s.tck && !tck_q_r;
  wire tck_fall = !pins_s.tck && tck_q_r;

  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  tap_state_t state_r;
  tap_state_t state_nxt;
  tap_state_t state_step;

  // sixteen states, branch by mode-select level
  always_comb begin
    state_step = state_r;
    case (state_r)
      ST_RESET:      state_step = pins_s.tms ? ST_RESET     : ST_IDLE;
      ST_IDLE:       state_step = pins_s.tms ? ST_SEL_DR    : ST_IDLE;
      ST_SEL_DR:     state_step = pins_s.tms ? ST_SEL_IR    : ST_CAPTURE_DR;
      ST_CAPTURE_DR: state_step = pins_s.tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
      ST_SHIFT_DR:   state_step = pins_s.tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
      ST_EXIT1_DR:   state_step = pins_s.tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:   state_step = pins_s.tms ? ST_EXIT2_DR  : ST_PAUSE_DR;
      ST_EXIT2_DR:   state_step = pins_s.tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR:  state_step = pins_s.tms ? ST_SEL_DR    : ST_IDLE;
      ST_SEL_IR:     state_step = pins_s.tms ? ST_RESET     : ST_CAPTURE_IR;
      ST_CAPTURE_IR: state_step = pins_s.tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
      ST_SHIFT_IR:   state_step = pins_s.tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
      ST_EXIT1_IR:   state_step = pins_s.tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:   state_step = pins_s.tms ? ST_EXIT2_IR  : ST_PAUSE_IR;
      ST_EXIT2_IR:   state_step = pins_s.tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR:  state_step = pins_s.tms ? ST_SEL_DR    : ST_IDLE;
      default:       state_step = ST_RESET;
    endcase
  end

  // every path with tms high ends in reset within five rises
  assign state_nxt = tck_rise ? state_step : state_r;

  // system reset stands in for power-on; there is no test-reset pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // state decode
  // ------------------------------------------------------------
  wire in_reset      = (state_r == ST_RESET);
  wire in_capture_ir = (state_r == ST_CAPTURE_IR);
  wire in_shift_ir   = (state_r == ST_SHIFT_IR);
  wire in_update_ir  = (state_r == ST_UPDATE_IR);
  wire in_capture_dr = (state_r == ST_CAPTURE_DR);
  wire in_shift_dr   = (state_r == ST_SHIFT_DR);
  wire in_update_dr  = (state_r == ST_UPDATE_DR);
  wire in_shift      = in_shift_ir || in_shift_dr;

  // ------------------------------------------------------------
  // instruction register
  // ------------------------------------------------------------
  logic [IR_W-1:0] ir_sr_r;
  logic [IR_W-1:0] ir_sr_nxt;
  logic [IR_W-1:0] ir_r;
  logic [IR_W-1:0] ir_nxt;

  // exits and pauses fall through both chains untouched
  assign ir_sr_nxt =
    (tck_rise && in_capture_ir) ? IR_CAPTURE :
    (tck_rise && in_shift_ir)   ? {pins_s.tdi, ir_sr_r[IR_W-1:1]} :
                                  ir_sr_r;

  // latch on the falling edge inside update so the new code is stable by the next rise
  assign ir_nxt =
    in_reset                     ? IR_RESET :
    (tck_fall && in_update_ir)   ? ir_sr_r  :
                                   ir_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ir_sr_r <= IR_CAPTURE;
    end else begin
      ir_sr_r <= ir_sr_nxt;
    end
  end

  // the live code moves only at update or in reset, never while shifting
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ir_r <= IR_RESET;
    end else begin
      ir_r <= ir_nxt;
    end
  end

  // ------------------------------------------------------------
  // data register selection
  // ------------------------------------------------------------
  // unknown codes fall back to bypass so the chain length stays defined
  wire sel_id     = (ir_r == IR_IDCODE);
  wire sel_data   = (ir_r == IR_DATA);
  wire sel_status = (ir_r == IR_STATUS);
  wire sel_bypass = !(sel_id || sel_data || sel_status);

  // ------------------------------------------------------------
  // receive stage in front of the fifo
  // ------------------------------------------------------------
  // the test side cannot be paused, so a word that finds the stage still
  // occupied is dropped and flagged rather than overwriting its predecessor
  logic              pend_valid_r;
  logic              pend_valid_nxt;
  logic [DATA_W-1:0] pend_data_r;
  logic [DATA_W-1:0] pend_data_nxt;
  logic              ovf_r;
  logic              ovf_nxt;
  logic              fifo_in_ready;

  logic [DR_W-1:0]   dr_sr_r;
  logic [DR_W-1:0]   dr_sr_nxt;
  logic              byp_r;
  logic              byp_nxt;

  wire update_data = tck_fall && in_update_dr && sel_data;
  wire pend_push   = pend_valid_r && fifo_in_ready;
  wire pend_room   = !pend_valid_r || pend_push;
  wire status_read = tck_rise && in_capture_dr && sel_status;

  assign pend_valid_nxt = (update_data && pend_room) ? 1'b1 :
                          pend_push                  ? 1'b0 :
                                                       pend_valid_r;
  assign pend_data_nxt  = (update_data && pend_room) ? dr_sr_r[DATA_W-1:0] : pend_data_r;

  // a fresh overflow in the read cycle survives the clear
  assign ovf_nxt = (update_data && !pend_room) ? 1'b1 :
                   status_read                 ? 1'b0 :
                                                 ovf_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_valid_r <= 1'b0;
      pend_data_r  <= '0;
    end else begin
      pend_valid_r <= pend_valid_nxt;
      pend_data_r  <= pend_data_nxt;
    end
  end

  // sticky until the status chain is captured
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ovf_r <= 1'b0;
    end else begin
      ovf_r <= ovf_nxt;
    end
  end

  word_fifo #(
    .W     (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (pend_valid_r),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_data_r),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );

  // ------------------------------------------------------------
  // data shift path
  // ------------------------------------------------------------
  logic [DR_W-1:0] status_word;
  logic [DR_W-1:0] cap_word;

  always_comb begin
    status_word              = '0;
    status_word[ST_PEND_BIT] = pend_valid_r;
    status_word[ST_OVF_BIT]  = ovf_r;
    status_word[ST_FULL_BIT] = !fifo_in_ready;
  end

  assign cap_word = sel_id     ? ID_VALUE :
                    sel_status ? status_word :
                                 DR_W'(cap_data);

  // full-width register: a data word lands in its low bits after exactly 32 shifts
  assign dr_sr_nxt =
    (tck_rise && in_capture_dr) ? cap_word :
    (tck_rise && in_shift_dr)   ? {pins_s.tdi, dr_sr_r[DR_W-1:1]} :
                                  dr_sr_r;

  assign byp_nxt =
    (tck_rise && in_capture_dr) ? 1'b0 :
    (tck_rise && in_shift_dr)   ? pins_s.tdi :
                                  byp_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dr_sr_r <= '0;
    end else begin
      dr_sr_r <= dr_sr_nxt;
    end
  end

  // one-bit chain for bypass and for unknown codes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      byp_r <= 1'b0;
    end else begin
      byp_r <= byp_nxt;
    end
  end

  // ------------------------------------------------------------
  // serial output
  // ------------------------------------------------------------
  // changes on the falling edge so the far side samples a settled bit on the rise
  logic tdo_r;
  logic tdo_nxt;
  logic tdo_oe_r;
  logic tdo_oe_nxt;

  wire tdo_bit = in_shift_ir ? ir_sr_r[0] :
                 sel_bypass  ? byp_r :
                               dr_sr_r[0];

  assign tdo_nxt    = tck_fall ? (in_shift ? tdo_bit : 1'b0) : tdo_r;
  assign tdo_oe_nxt = tck_fall ? in_shift : tdo_oe_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tdo_r <= 1'b0;
    end else begin
      tdo_r <= tdo_nxt;
    end
  end

  // released between shifts; the far side's pull-up gives the idle level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_oe_r <= tdo_oe_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign tdo_out     = tdo_r;
  assign tdo_oe      = tdo_oe_r;
  assign tap_state   = state_r;
  assign active_ir   = ir_r;
  assign logic_reset = in_reset;

endmodule // tap_ctrl

/* File: bench/tap_ctrl_asserts.sv */
// port assertions for the test access port controller, bound to tap_ctrl
// assumes each tck level lasts at least four clk periods
`timescale 1ns/1ps

module tap_ctrl_asserts
  import tap_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int DEPTH  = FIFO_DEPTH
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // test pins
  input wire tap_pins_t         pins_in,
  input wire logic              tdo_out,
  input wire logic              tdo_oe,
  // data side
  input wire logic [DATA_W-1:0] cap_data,
  input wire logic              word_valid,
  input wire logic              word_ready,
  input wire logic [DATA_W-1:0] word_data,
  // controller view
  input wire tap_state_t        tap_state,
  input wire logic [IR_W-1:0]   active_ir,
  input wire logic              logic_reset
);
  // --------------------
  // tck rise as the controller sees it, run of tms ones
  // --------------------
  logic [2:0] tck_h;
  logic [2:0] tms_h;
  logic [2:0] ones_r;
  logic [2:0] ones_nxt;
  logic       rise;
  assign rise     = tck_h[1] & ~tck_h[2];
  assign ones_nxt = !rise ? ones_r : !tms_h[1] ? 3'h0 : (ones_r == 3'h7) ? ones_r : ones_r + 3'h1;
  always_ff @(posedge clk) begin
    tck_h  <= {tck_h[1:0], pins_in.tck};
    tms_h  <= {tms_h[1:0], pins_in.tms};
    ones_r <= sys_rst ? 3'h0 : ones_nxt;
  end

  function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
    case (s)
      ST_RESET: return m ? ST_RESET : ST_IDLE;
      ST_IDLE: return m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: return m ? ST_SEL_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: return m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: return m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: return m ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: return m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: return m ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_SEL_IR: return m ? ST_RESET : ST_CAPTURE_IR;
      ST_CAPTURE_IR: return m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: return m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: return m ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: return m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: return m ? ST_UPDATE_IR : ST_SHIFT_IR;
      default: return m ? ST_SEL_DR : ST_IDLE;
    endcase
  endfunction

  // --------------------
  // properties
  // --------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_next; rise |=> tap_state == tap_next($past(tap_state), $past(tms_h[1])); endproperty
  a_next: assert property (p_next) else $error("wrong state step after tck rise");
  property p_hold; !rise |=> $stable(tap_state); endproperty
  a_hold: assert property (p_hold) else $error("state moved without tck rise");
  property p_start; $fell(sys_rst) |-> tap_state == ST_RESET && active_ir == IR_RESET && !tdo_oe; endproperty
  a_start: assert property (p_start) else $error("bad state after reset");
  property p_five; ones_r >= 3'h5 |-> tap_state == ST_RESET; endproperty
  a_five: assert property (p_five) else $error("five tms ones missed reset state");
  property p_lreset; logic_reset == (tap_state == ST_RESET); endproperty
  a_lreset: assert property (p_lreset) else $error("logic_reset disagrees with state");
  property p_oe; tdo_oe |-> tap_state inside {ST_SHIFT_IR, ST_SHIFT_DR, ST_EXIT1_IR, ST_EXIT1_DR}; endproperty
  a_oe: assert property (p_oe) else $error("tdo driven outside a shift");
  property p_float; !tdo_oe |-> !tdo_out; endproperty
  a_float: assert property (p_float) else $error("tdo level while released");
  property p_capir; $rose(tdo_oe) && tap_state == ST_SHIFT_IR |-> tdo_out == IR_CAPTURE[0]; endproperty
  a_capir: assert property (p_capir) else $error("first instruction bit out wrong");
  property p_irupd; $changed(active_ir) |-> tap_state inside {ST_UPDATE_IR, ST_RESET}; endproperty
  a_irupd: assert property (p_irupd) else $error("instruction changed outside update");
  property p_transit; tap_state inside {ST_PAUSE_IR, ST_EXIT2_IR, ST_PAUSE_DR, ST_EXIT2_DR} |=>
    !tdo_oe && $stable(active_ir); endproperty
  a_transit: assert property (p_transit) else $error("register action in transit state");
  property p_stand; word_valid && !word_ready |=> word_valid && $stable(word_data); endproperty
  a_stand: assert property (p_stand) else $error("stalled word not held");

  c_pause: cover property (tap_state == ST_PAUSE_DR);
  c_full: cover property (word_valid && !word_ready);
  c_five: cover property (ones_r == 3'h5);
endmodule // tap_ctrl_asserts

bind tap_ctrl tap_ctrl_asserts #(.DATA_W(DATA_W), .DEPTH(DEPTH)) chk (
  .clk(clk), .sys_rst(sys_rst), .pins_in(pins_in), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
  .cap_data(cap_data), .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
  .tap_state(tap_state), .active_ir(active_ir), .logic_reset(logic_reset)
);

/* File: bench/tap_host_model.sv */
// far-side test controller: drives tck, tms and tdi, reads tdo through a pull-up
// assumes the controller samples its pins with a clock eight times faster than tck
`timescale 1ns/1ps

module tap_host_model
  import tap_pkg::*;
#(
  parameter int HALF_NS = 160
) (
  // test pins
  output tap_pins_t pins,
  // serial return
  input  wire logic tdo_out,
  input  wire logic tdo_oe
);
  logic tdo_w;
  // released tdo floats up to the pull-up
  assign tdo_w = tdo_oe ? tdo_out : 1'b1;
  // tck stands low between frames
  initial pins = '0;

  // one tck period; tms and tdi move only while tck is low
  task automatic step(input logic m, input logic d, output logic q);
    pins.tms = m;
    pins.tdi = d;
    #(HALF_NS);
    q = tdo_w;
    pins.tck = 1'b1;
    #(HALF_NS);
    pins.tck = 1'b0;
  endtask

  // idle to shift, n bits lsb first, optional pause, update, idle again
  task automatic scan(input logic ir, input int n, input logic [31:0] din, input logic pause,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    if (pause) begin
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b1, 1'b0, q);
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule // tap_host_model

/* File: bench/tap_ctrl_bench.sv */
// self-checking bench for tap_ctrl: host model on the pins, words checked from a queue
// assumes the host model and the bound checker are compiled with it
`timescale 1ns/1ps

module tap_ctrl_bench
  import tap_pkg::*;
;
  localparam logic [31:0] PEND_FULL = (32'h1 << ST_PEND_BIT) | (32'h1 << ST_FULL_BIT);
  localparam logic [31:0] OVF       = 32'h1 << ST_OVF_BIT;

  logic            clk;
  logic            sys_rst;
  tap_pins_t       pins;
  logic            tdo_out;
  logic            tdo_oe;
  logic [31:0]     cap_data;
  logic            word_valid;
  logic            word_ready;
  logic [31:0]     word_data;
  tap_state_t      tap_state;
  logic [IR_W-1:0] active_ir;
  logic            logic_reset;
  int              bad_count;
  int              compares;
  logic [31:0]     words_q[$];

  tap_ctrl #(.DATA_W(32), .DEPTH(FIFO_DEPTH)) dut (
    .clk(clk), .sys_rst(sys_rst), .pins_in(pins), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .cap_data(cap_data), .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
    .tap_state(tap_state), .active_ir(active_ir), .logic_reset(logic_reset)
  );
  tap_host_model host (.pins(pins), .tdo_out(tdo_out), .tdo_oe(tdo_oe));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  // --------------------
  // checking and closing
  // --------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    bad_count++;
    results();
  end

  task automatic load_ir(input logic [3:0] code);
    logic [31:0] o;
    host.scan(1'b1, IR_W, 32'(code), code == IR_STATUS, o);
    check(o, 32'(IR_CAPTURE));
    check(32'(active_ir), 32'(code));
    check(32'(tap_state), 32'(ST_IDLE));
  endtask

  // fresh capture value before each data scan
  task automatic dr(input int n, input logic [31:0] din, input logic pause, output logic [31:0] o);
    @(posedge clk);
    #1 cap_data = $urandom();
    host.scan(1'b0, n, din, pause, o);
    check(32'(tap_state), 32'(ST_IDLE));
  endtask

  task automatic reset_check();
    @(posedge clk);
    #1;
    check(32'(tap_state), 32'(ST_RESET));
    check(32'(active_ir), 32'(IR_RESET));
    check({31'h0, tdo_oe}, 32'h0);
  endtask

  // --------------------
  // scenarios
  // --------------------
  initial begin
    logic [31:0] o;
    logic [31:0] d;
    logic        q;
    sys_rst = 1'b1;
    cap_data = '0;
    word_ready = 1'b0;
    bad_count = 0;
    compares = 0;
    void'($urandom(32'h3797aca4));
    repeat (16) @(posedge clk);
    #1 sys_rst = 1'b0;
    reset_check();
    host.step(1'b0, 1'b0, q);
    dr(32, $urandom(), 1'b1, o);
    check(o, ID_VALUE);
    for (int k = 0; k < 2; k++) begin
      load_ir(k ? 4'h7 : IR_BYPASS);
      d = $urandom();
      dr(8, d, 1'b0, o);
      check(o, {24'h0, d[6:0], 1'b0});
    end
    // consumer stalled: pend, fifo and output hold 34, the 35th is dropped
    load_ir(IR_DATA);
    for (int k = 0; k < 35; k++) begin
      d = $urandom();
      dr(32, d, 1'b0, o);
      check(o, cap_data);
      if (k < 34) words_q.push_back(d);
    end
    load_ir(IR_STATUS);
    dr(32, '0, 1'b0, o);
    check(o, PEND_FULL | OVF);
    dr(32, '0, 1'b0, o);
    check(o, PEND_FULL);
    for (int t = 0; t < 3000 && words_q.size() > 0; t++) begin
      @(posedge clk);
      #1 word_ready = 1'($urandom());
      if (word_valid === 1'b1 && word_ready) check(word_data, words_q.pop_front());
    end
    if (words_q.size() != 0) begin
      bad_count++;
      results();
    end
    @(posedge clk);
    #1 word_ready = 1'b1;
    dr(32, '0, 1'b0, o);
    check(o, 32'h0);
    check({31'h0, word_valid}, 32'h0);
    // five ones from inside a data shift
    load_ir(IR_BYPASS);
    for (int i = 0; i < 8; i++) host.step(i == 0 || i > 2, 1'b0, q);
    check(32'(tap_state), 32'(ST_RESET));
    check(32'(active_ir), 32'(IR_RESET));
    check({31'h0, logic_reset}, 32'h1);
    host.step(1'b0, 1'b0, q);
    load_ir(IR_DATA);
    @(posedge clk);
    #1 sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 sys_rst = 1'b0;
    reset_check();
    results();
  end
endmodule // tap_ctrl_bench
